// file: hdl/aocc_consts.vh
// constants for the auxiliary converter offset and gain correction
// assumes a 32-bit ahb-lite register bus and a 16-bit offset-binary result
`ifndef AOCC_CONSTS_VH
`define AOCC_CONSTS_VH

// register byte addresses
`define AOCC_ADDR_GAIN_GN1      32'h0000_2240
`define AOCC_ADDR_OFFSET_GN1    32'h0000_2244
`define AOCC_ADDR_OFFSET_GN1P5  32'h0000_22CC
`define AOCC_ADDR_RESULT        32'h0000_2300

// calibration field layout
`define AOCC_CAL_MSB            14
`define AOCC_CAL_LSB            0
`define AOCC_CAL_W              15
`define AOCC_GAIN_SIGN_BIT      14
`define AOCC_GAIN_FRAC_BITS     14

// reset values
`define AOCC_GAIN_RESET         15'h4000
`define AOCC_OFFSET_RESET       15'h0000
`define AOCC_GAIN_UNITY         15'h4000
`define AOCC_GAIN_ILLEGAL       15'h0000

// result register fields
`define AOCC_RES_DATA_MSB       15
`define AOCC_RES_SEEN_BIT       16
`define AOCC_RES_CNT_LSB        24

// offset counts are quarter lsb: two fractional bits
`define AOCC_OFFSET_FRAC_BITS   2

// converter result coding
`define AOCC_RESULT_MID         16'h8000
`define AOCC_RESULT_MAX         16'hFFFF
`define AOCC_RESULT_MIN         16'h0000

// pga gain setting codes
`define AOCC_PGA_GAIN_1         2'h0
`define AOCC_PGA_GAIN_1P5       2'h1
`define AOCC_PGA_GAIN_2         2'h2
`define AOCC_PGA_GAIN_9         2'h3

// ahb-lite codes
`define AOCC_HTRANS_NONSEQ_BIT  1
`define AOCC_HRESP_OKAY         1'b0

`endif

// file: hdl/aocc_correction.v
// offset and gain correction of converter results, with ahb-lite registers
// assumes raw results and pga setting come from logic on hclk
//
// Behaviour
// - each offset value is a 15-bit two's complement field in bits 14:0
// - one offset count is a quarter of one result lsb
// - 3FFF adds 4095.75, 0001 adds 0.25, 7FFF subtracts 0.25, 4000 -4096
// - gain value: bit 14 weighs one, bits 13:0 fraction
// - result multiplied by gain; 4000 is unity, 2000 half, 7FFF about two
// - gain value zero forces a result of 8000 at pga one
// - unity-pga gain applies except tia and temperature channels, pga one only
// - unity-pga offset applies to auxiliary conversions only at pga one
// - separate offset value applies at pga gain 1.5
// - reset gives unity gain and zero offsets, results pass unchanged
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
`include "aocc_consts.vh"

module aocc_correction #(
    parameter RES_W = 16,
    parameter CNT_W = 8
) (
    input  wire                hclk,
    input  wire                hresetn,
    input  wire                hsel,
    input  wire [31:0]         haddr,
    input  wire [1:0]          htrans,
    input  wire                hwrite,
    input  wire [2:0]          hsize,
    input  wire [31:0]         hwdata,
    input  wire                hready,
    output reg                 hreadyout,
    output reg                 hresp,
    output reg  [31:0]         hrdata,
    input  wire [RES_W-1:0]    raw_result,
    input  wire                raw_valid,
    input  wire [1:0]          pga_gain_sel,
    input  wire                chan_excluded,
    output reg  [RES_W-1:0]    conversion_result_register,
    output reg                 result_valid
);

////////////////////////////////////////////////////////////////////////////
// register bus
////////////////////////////////////////////////////////////////////////////

reg  [`AOCC_CAL_W-1:0]    unity_gain_aux_gain_correction_r;
reg  [`AOCC_CAL_W-1:0]    unity_gain_aux_offset_correction_r;
reg  [`AOCC_CAL_W-1:0]    gain_one_and_half_offset_correction_r;
reg                       wr_pend_r;
reg  [31:0]               wr_addr_r;
reg  [31:0]               rd_word_nxt;
reg  [`AOCC_CAL_W-1:0]    gain_rd;
reg  [`AOCC_CAL_W-1:0]    off1_rd;
reg  [`AOCC_CAL_W-1:0]    off15_rd;
reg                       seen_r;
reg  [CNT_W-1:0]          count_r;
wire                      addr_phase;
wire                      wr_gain;
wire                      wr_off1;
wire                      wr_off15;
wire [`AOCC_CAL_W-1:0]    wr_field;
wire [29:0]               wr_idx;
wire [29:0]               rd_idx;
wire [31:0]               gain_word;
wire [31:0]               off1_word;
wire [31:0]               off15_word;

// byte addresses and word indices of the registers
localparam [31:0] ADDR_GAIN  = `AOCC_ADDR_GAIN_GN1;
localparam [31:0] ADDR_OFF1  = `AOCC_ADDR_OFFSET_GN1;
localparam [31:0] ADDR_OFF15 = `AOCC_ADDR_OFFSET_GN1P5;
localparam [31:0] ADDR_RES   = `AOCC_ADDR_RESULT;
localparam [29:0] IDX_GAIN   = ADDR_GAIN[31:2];
localparam [29:0] IDX_OFF1   = ADDR_OFF1[31:2];
localparam [29:0] IDX_OFF15  = ADDR_OFF15[31:2];
localparam [29:0] IDX_RES    = ADDR_RES[31:2];
localparam [31:0] WORD_ZERO  = 32'h0000_0000;

// hsize not decoded: whole words only
assign addr_phase = hsel & htrans[`AOCC_HTRANS_NONSEQ_BIT] & hready;
assign wr_field   = hwdata[`AOCC_CAL_MSB:`AOCC_CAL_LSB];
assign wr_idx     = wr_addr_r[31:2];
assign rd_idx     = haddr[31:2];
assign wr_gain    = wr_pend_r & (wr_idx == IDX_GAIN);
assign wr_off1    = wr_pend_r & (wr_idx == IDX_OFF1);
assign wr_off15   = wr_pend_r & (wr_idx == IDX_OFF15);

// address phase capture for writes
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wr_pend_r <= 1'b0;
        wr_addr_r <= 32'h0000_0000;
    end else if (hready) begin
        wr_pend_r <= addr_phase & hwrite;
        wr_addr_r <= haddr;
    end
end

// unity-pga gain value, data phase write
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        unity_gain_aux_gain_correction_r <= `AOCC_GAIN_RESET;
    end else if (wr_gain) begin
        unity_gain_aux_gain_correction_r <= wr_field;
    end
end

// unity-pga offset value, data phase write
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        unity_gain_aux_offset_correction_r <= `AOCC_OFFSET_RESET;
    end else if (wr_off1) begin
        unity_gain_aux_offset_correction_r <= wr_field;
    end
end

// pga 1.5 offset value, data phase write
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        gain_one_and_half_offset_correction_r <= `AOCC_OFFSET_RESET;
    end else if (wr_off15) begin
        gain_one_and_half_offset_correction_r <= wr_field;
    end
end

// read values, with bypass of a write still in its data phase
always @* begin
    gain_rd  = wr_gain  ? wr_field : unity_gain_aux_gain_correction_r;
    off1_rd  = wr_off1  ? wr_field : unity_gain_aux_offset_correction_r;
    off15_rd = wr_off15 ? wr_field : gain_one_and_half_offset_correction_r;
end

////////////////////////////////////////////////////////////////////////////
// register read path
////////////////////////////////////////////////////////////////////////////

// read words; reserved upper bits are zero
assign gain_word  = {{(32-`AOCC_CAL_W){1'b0}}, gain_rd};
assign off1_word  = {{(32-`AOCC_CAL_W){1'b0}}, off1_rd};
assign off15_word = {{(32-`AOCC_CAL_W){1'b0}}, off15_rd};

// read mux; unmapped words read zero
always @* begin
    rd_word_nxt = WORD_ZERO;
    case (rd_idx)
        IDX_GAIN: begin
            rd_word_nxt = gain_word;
        end
        IDX_OFF1: begin
            rd_word_nxt = off1_word;
        end
        IDX_OFF15: begin
            rd_word_nxt = off15_word;
        end
        IDX_RES: begin
            rd_word_nxt[RES_W-1:0] = conversion_result_register;
            rd_word_nxt[`AOCC_RES_SEEN_BIT] = seen_r;
            rd_word_nxt[`AOCC_RES_CNT_LSB+CNT_W-1:`AOCC_RES_CNT_LSB] =
                count_r;
        end
        default: begin
            rd_word_nxt = WORD_ZERO;
        end
    endcase
end

// zero wait state, always okay
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hreadyout <= 1'b1;
        hresp     <= `AOCC_HRESP_OKAY;
    end else begin
        hreadyout <= 1'b1;
        hresp     <= `AOCC_HRESP_OKAY;
    end
end

// read data loaded at the address phase, stands until the next read
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hrdata <= WORD_ZERO;
    end else if (addr_phase & ~hwrite) begin
        hrdata <= rd_word_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////
// selection of correction values
////////////////////////////////////////////////////////////////////////////

reg  signed [`AOCC_CAL_W-1:0]  offset_sel;
reg         [`AOCC_CAL_W-1:0]  gain_sel;
reg                            gain_zero;
wire                           pga_one;
wire                           pga_one_half;

// excluded channels and other pga settings pass uncorrected
assign pga_one      = ~chan_excluded &
                      (pga_gain_sel == `AOCC_PGA_GAIN_1);
assign pga_one_half = ~chan_excluded &
                      (pga_gain_sel == `AOCC_PGA_GAIN_1P5);

// offset for the active pga setting
always @* begin
    if (pga_one) begin
        offset_sel = unity_gain_aux_offset_correction_r;
    end else if (pga_one_half) begin
        offset_sel = gain_one_and_half_offset_correction_r;
    end else begin
        offset_sel = 15'h0000;
    end
end

// gain applies at pga one only
always @* begin
    if (pga_one) begin
        gain_sel = unity_gain_aux_gain_correction_r;
    end else begin
        gain_sel = `AOCC_GAIN_UNITY;
    end
end

// illegal zero gain forces a mid-scale result
always @* begin
    gain_zero = pga_one & (unity_gain_aux_gain_correction_r ==
                           `AOCC_GAIN_ILLEGAL);
end

////////////////////////////////////////////////////////////////////////////
// stage one: centre the result and add the offset
////////////////////////////////////////////////////////////////////////////

wire signed [RES_W:0]     centred;
wire signed [RES_W+3:0]   centred_q;
wire signed [RES_W+3:0]   offset_ext;
wire signed [RES_W+3:0]   sum_nxt;
reg  signed [RES_W+3:0]   sum_r;
reg         [`AOCC_CAL_W-1:0] gain_r;
reg                       zero_r;
reg                       s1_valid_r;

assign centred    = $signed({1'b0, raw_result}) -
                    $signed({1'b0, `AOCC_RESULT_MID});
// quarter-lsb units: two fraction bits under the result lsb
assign centred_q  = {{3{centred[RES_W]}}, centred} <<<
                    `AOCC_OFFSET_FRAC_BITS;
assign offset_ext = {{(RES_W+4-`AOCC_CAL_W){offset_sel[`AOCC_CAL_W-1]}},
                     offset_sel};
// offset added before the gain is applied
assign sum_nxt    = centred_q + offset_ext;

// sample strobe pipe
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        s1_valid_r <= 1'b0;
    end else begin
        s1_valid_r <= raw_valid;
    end
end

// operands held for stage two
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        sum_r  <= {(RES_W+4){1'b0}};
        gain_r <= `AOCC_GAIN_UNITY;
        zero_r <= 1'b0;
    end else if (raw_valid) begin
        sum_r  <= sum_nxt;
        gain_r <= gain_sel;
        zero_r <= gain_zero;
    end
end

////////////////////////////////////////////////////////////////////////////
// stage two: gain, rounding, recentring and clamp
////////////////////////////////////////////////////////////////////////////

localparam PROD_W = RES_W + 4 + `AOCC_CAL_W + 1;
localparam SHIFT  = `AOCC_GAIN_FRAC_BITS + `AOCC_OFFSET_FRAC_BITS;

wire signed [`AOCC_CAL_W:0] gain_s;
wire signed [PROD_W-1:0]    prod;
wire signed [PROD_W-1:0]    prod_rnd;
wire signed [PROD_W-1:0]    half_lsb;
wire signed [PROD_W-1:0]    scaled;
wire signed [PROD_W-1:0]    recentred;
reg         [RES_W-1:0]     final_nxt;

// bit 14 weighs one, bits 13:0 are the fraction
assign gain_s    = $signed({1'b0, gain_r});
assign prod      = sum_r * gain_s;
// round half up before the fraction bits are dropped
assign half_lsb  = {{(PROD_W-1){1'b0}}, 1'b1} <<< (SHIFT-1);
assign prod_rnd  = prod + half_lsb;
assign scaled    = prod_rnd >>> SHIFT;
assign recentred = scaled + $signed({{(PROD_W-RES_W){1'b0}},
                                     `AOCC_RESULT_MID});

// clamp to the converter code range
always @* begin
    if (zero_r) begin
        final_nxt = `AOCC_RESULT_MID;
    end else if (recentred < 0) begin
        final_nxt = `AOCC_RESULT_MIN;
    end else if (recentred > $signed({{(PROD_W-RES_W){1'b0}},
                                      `AOCC_RESULT_MAX})) begin
        final_nxt = `AOCC_RESULT_MAX;
    end else begin
        final_nxt = recentred[RES_W-1:0];
    end
end

////////////////////////////////////////////////////////////////////////////
// result and status registers
////////////////////////////////////////////////////////////////////////////

// corrected result, held between samples
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        conversion_result_register <= {RES_W{1'b0}};
    end else if (s1_valid_r) begin
        conversion_result_register <= final_nxt;
    end
end

// one-cycle pulse per result
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        result_valid <= 1'b0;
    end else begin
        result_valid <= s1_valid_r;
    end
end

// status: result seen flag and wrapping result count
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        seen_r  <= 1'b0;
        count_r <= {CNT_W{1'b0}};
    end else if (s1_valid_r) begin
        seen_r  <= 1'b1;
        count_r <= count_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
end

endmodule // aocc_correction

// file: verification/aocc_asserts.sv
// port checker for the offset and gain correction block
// assumes a bind onto aocc_correction, one clock hclk
`timescale 1ns/1ns
`include "aocc_consts.vh"
module aocc_asserts #(
    parameter RES_W = 16
) (
    input wire             hclk,
    input wire             hresetn,
    input wire             hsel,
    input wire [31:0]      haddr,
    input wire [1:0]       htrans,
    input wire             hwrite,
    input wire [2:0]       hsize,
    input wire [31:0]      hwdata,
    input wire             hready,
    input wire             hreadyout,
    input wire             hresp,
    input wire [31:0]      hrdata,
    input wire [RES_W-1:0] raw_result,
    input wire             raw_valid,
    input wire [1:0]       pga_gain_sel,
    input wire             chan_excluded,
    input wire [RES_W-1:0] conversion_result_register,
    input wire             result_valid
);
    wire cal = haddr == `AOCC_ADDR_GAIN_GN1 ||
               haddr == `AOCC_ADDR_OFFSET_GN1 ||
               haddr == `AOCC_ADDR_OFFSET_GN1P5;
    wire rd  = hsel && htrans[1] && hready && !hwrite;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////////////////////////////////////
    a_result_latency: assert property (raw_valid |-> ##2 result_valid)
        else $error("result pulse late or missing");
    a_valid_cause: assert property (result_valid |-> $past(raw_valid, 2))
        else $error("result pulse without sample");
    a_excl_pass: assert property (raw_valid && chan_excluded |-> ##2
        conversion_result_register == $past(raw_result, 2))
        else $error("excluded channel was corrected");
    a_pga_other: assert property (raw_valid && pga_gain_sel[1] |-> ##2
        conversion_result_register == $past(raw_result, 2))
        else $error("other pga setting was corrected");
    a_rsvd_zero: assert property (rd && cal |=> hrdata[31:15] == 17'h0)
        else $error("upper calibration bits not zero");
    a_unmapped_zero: assert property (rd && !cal &&
        haddr != `AOCC_ADDR_RESULT |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_result_hold: assert property (!result_valid |->
        $stable(conversion_result_register))
        else $error("result changed without pulse");
    a_ready_okay: assert property (hreadyout && hresp == 1'b0)
        else $error("bus wait or error seen");
    c_pga_one: cover property (raw_valid && pga_gain_sel == 2'h0);
    c_pga_half: cover property (raw_valid && pga_gain_sel == 2'h1);
    c_excl: cover property (raw_valid && chan_excluded);
endmodule // aocc_asserts

// file: verification/aocc_tb.sv
// register and datapath bench for the correction block
// assumes aocc_correction with zero wait ahb-lite and 2-cycle datapath
`timescale 1ns/1ns
`include "aocc_consts.vh"
module tb;
    logic        hclk = 0;
    logic        hresetn = 0;
    logic        hsel = 0;
    logic        hwrite = 0;
    logic [31:0] haddr = 0;
    logic [31:0] hwdata = 0;
    logic [1:0]  htrans = 0;
    logic [1:0]  pga = 0;
    logic [15:0] raw = 0;
    logic [15:0] last = 0;
    logic        raw_valid = 0;
    logic        excl = 0;
    logic [14:0] g1 = 15'h4000;
    logic [14:0] o1 = 0;
    logic [14:0] o15 = 0;
    logic [31:0] rd;
    wire         hreadyout;
    wire         hresp;
    wire         result_valid;
    wire  [31:0] hrdata;
    wire  [15:0] res;
    int          n_fail = 0;
    int          checks = 0;
    int          n_smp = 0;
    logic [31:0] adr [3] = '{`AOCC_ADDR_GAIN_GN1, `AOCC_ADDR_OFFSET_GN1,
                             `AOCC_ADDR_OFFSET_GN1P5};
    logic [14:0] offs [5] = '{15'h3FFF, 15'h0001, 15'h0, 15'h7FFF, 15'h4000};
    logic [14:0] gns [6] = '{15'h7FFF, 15'h4001, 15'h3FFF, 15'h2000,
                             15'h0001, 15'h0};
    aocc_correction dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .raw_result(raw),
        .raw_valid(raw_valid), .pga_gain_sel(pga), .chan_excluded(excl),
        .conversion_result_register(res), .result_valid(result_valid));
    always #25 hclk = ~hclk;
    ////////////////////////////////////////////////////////////////////////
    task results;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task setcal(input logic [14:0] a, input logic [14:0] b,
                input logic [14:0] g);
        o1 = a;
        o15 = b;
        g1 = g;
        ahb(1, `AOCC_ADDR_OFFSET_GN1, {17'h0, a});
        ahb(1, `AOCC_ADDR_OFFSET_GN1P5, {17'h0, b});
        ahb(1, `AOCC_ADDR_GAIN_GN1, {17'h0, g});
    endtask
    function automatic logic [15:0] model(input logic [15:0] r,
                                          input logic [1:0] p, input logic e);
        longint s;
        logic [14:0] g;
        if (e || p[1])
            return r;
        g = p[0] ? 15'h4000 : g1;
        if (g == 15'h0)
            return 16'h8000;
        s = 4 * (longint'(r) - 32768) + longint'($signed(p[0] ? o15 : o1));
        s = ((s * longint'(g)) + 32768) >>> 16;
        s = s + 32768;
        return s < 0 ? 16'h0 : (s > 65535 ? 16'hFFFF : s[15:0]);
    endfunction
    task smp(input logic [15:0] r, input logic [1:0] p, input logic e);
        @(posedge hclk);
        raw <= r;
        pga <= p;
        excl <= e;
        raw_valid <= 1;
        @(posedge hclk);
        raw_valid <= 0;
        @(posedge hclk);
        #1;
        last = model(r, p, e);
        n_smp++;
        chk(result_valid, 1);
        chk(res, last);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1;
        foreach (adr[i]) begin
            ahb(0, adr[i], 0);
            chk(rd, i == 0 ? 32'h4000 : 32'h0);
        end
        smp(16'h1234, 0, 0);
        ahb(0, 32'h0000_2248, 0);
        chk(rd, 32'h0);
        foreach (adr[i]) begin
            ahb(1, adr[i], 32'hFFFF_FFFF);
            ahb(0, adr[i], 0);
            chk(rd, 32'h7FFF);
        end
        foreach (offs[i]) begin
            setcal(offs[i], 15'h0002, 15'h4000);
            smp(16'h8000, 0, 0);
            smp(16'hFFF0, 0, 0);
            smp(16'h0003, 0, 0);
            smp(16'h8000, 1, 0);
        end
        foreach (gns[i]) begin
            setcal(15'h0004, 15'h7FFF, gns[i]);
            smp(16'hC000, 0, 0);
            smp(16'h4000, 1, 0);
            smp(16'h4000, 2, 0);
            smp(16'h9000, 3, 0);
            smp(16'hA000, 0, 1);
        end
        ahb(0, `AOCC_ADDR_RESULT, 0);
        chk(rd, {n_smp[7:0], 7'h0, 1'b1, last});
        results;
    end
    initial begin
        repeat (5000) @(posedge hclk);
        n_fail++;
        results;
    end
endmodule // tb
bind aocc_correction aocc_asserts #(.RES_W(RES_W)) u_chk (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .raw_result(raw_result), .raw_valid(raw_valid),
    .pga_gain_sel(pga_gain_sel), .chan_excluded(chan_excluded),
    .conversion_result_register(conversion_result_register),
    .result_valid(result_valid));
